// ==== board_ctrl_pkg.sv ====
// Package: offsets, field positions, reset values and timing for the board control bank
package board_ctrl_pkg;
	// Byte offsets within the APB window: the printed addresses are not all multiples of four,
	// so each printed offset is an index and the byte address is four times it
	localparam logic [31:0] ctrl_index        = 32'hf1600004;
	localparam logic [31:0] ctrl_status_index = 32'hf1600005;
	localparam logic [31:0] wd_temp_index     = 32'hf1600006;
	localparam logic [31:0] kick_index        = 32'hf1600007;
	localparam logic [31:0] irq_status_index  = 32'hf1600008;
	localparam logic [31:0] irq_mask_index    = 32'hf1600009;
	localparam logic [11:0] ctrl_addr         = 12'(ctrl_index * 4);
	localparam logic [11:0] ctrl_status_addr  = 12'(ctrl_status_index * 4);
	localparam logic [11:0] wd_temp_addr      = 12'(wd_temp_index * 4);
	localparam logic [11:0] kick_addr         = 12'(kick_index * 4);
	localparam logic [11:0] irq_status_addr   = 12'(irq_status_index * 4);
	localparam logic [11:0] irq_mask_addr     = 12'(irq_mask_index * 4);

	// Field positions
	localparam int floppy_eject_bit      = 2;
	localparam int reset_cause_clear_bit = 3;
	localparam int boot_override_bit     = 0;
	localparam int cable_bit             = 1;
	localparam int sensor1_bit           = 2;
	localparam int sensor2_bit           = 3;
	localparam int wd_irq_en_bit         = 0;
	localparam int wd_running_bit        = 1;
	localparam int temp_irq_en_bit       = 2;
	localparam int temp_pending_bit      = 3;
	localparam int kick_bit              = 3;
	localparam int ev_wd_expired_bit     = 0;
	localparam int ev_temp_alarm_bit     = 1;

	// Reset values and reserved-bit patterns
	localparam logic [7:0] ctrl_reset     = 8'h00;
	localparam logic [7:0] reserved_read  = 8'h00;
	localparam logic [3:0] reserved_nibble = 4'hf;
	localparam logic [7:0] mask_reset     = 8'h00;
	localparam logic [2:0] reset_cause_w  = 3'h0;

	// Watchdog timing
	localparam longint clk_hz          = 50000000;
	localparam longint wd_timeout_ms   = 3000;
	localparam longint wd_timeout_cyc  = (clk_hz / 1000) * wd_timeout_ms;
	localparam longint prescale_div    = 50000;
	localparam logic [15:0] prescale_max = 16'(prescale_div - 1);

	typedef struct packed {
		logic sensor1;
		logic sensor2;
		logic cable;
		logic wd_switch;
	} pins_s;

	// Synchroniser reset: alarm pins idle high, so no alarm edge is seen as reset releases
	localparam pins_s pins_idle = '{sensor1: 1'h1, sensor2: 1'h1, cable: 1'h0, wd_switch: 1'h0};
endpackage

// ==== board_ctrl_regs.sv ====
// Board control bank: control, status, temperature alarm and watchdog registers over APB
//
// Function
// - Control bit 2 is read/write, resets 0, drives floppy eject.
// - Writing control bit 3 clears all reset-cause flags.
// - Status bit 0 overrides boot select switch, resets 0, selects soldered flash.
// - Status bit 1 reads keyboard/mouse adapter cable presence.
// - Status bit 2 reads first sensor alarm level.
// - Status bit 3 reads second sensor alarm level.
// - Watchdog expires after three seconds without a trigger.
// - Watchdog register bit 0 enables the watchdog interrupt.
// - Watchdog register bit 1 reads 1 while the interval runs.
// - Watchdog register bit 2 enables the temperature interrupt.
// - Watchdog register bit 3 reads 1 while either alarm is active.
// - Trigger bit 3 starts watchdog if switch on; later writes restart.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module board_ctrl_regs #(
	parameter int unsigned wd_ticks = 3000
) (
	// APB
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [31:0]              paddr,
	input  wire logic [31:0]              pwdata,
	input  wire logic [3:0]               pstrb,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	// Board pins
	input  wire board_ctrl_pkg::pins_s    pins,
	input  wire logic                     boot_select_switch,
	input  wire logic [2:0]               reset_cause_in,
	// Outputs
	output logic                          floppy_eject,
	output logic                          boot_flash_select,
	output logic      [2:0]               reset_cause,
	output logic                          watchdog_expired,
	output logic                          watchdog_irq,
	output logic                          temp_irq,
	output logic                          irq
);
	typedef enum logic [1:0] {wd_idle, wd_run, wd_expired} wd_state_e;

	// Pin synchronisers
	board_ctrl_pkg::pins_s pins_meta_reg;
	board_ctrl_pkg::pins_s pins_sync_reg;
	logic boot_meta_reg;
	logic boot_sync_reg;

	logic [7:0]  ctrl_reg;
	logic        boot_override_reg;
	logic        wd_irq_en_reg;
	logic        temp_irq_en_reg;
	logic        kick_reg;
	logic [2:0]  cause_reg;
	logic [1:0]  ev_status_reg;
	logic [1:0]  ev_mask_reg;
	logic [15:0] prescale_reg;
	logic [31:0] tick_reg;
	wd_state_e   wd_state_reg;
	wd_state_e   wd_state_next;
	logic [31:0] prdata_reg;
	logic        temp_prev_reg;

	// Decode
	wire        access   = psel && penable;
	wire        wr       = access && pwrite && pstrb[0];
	wire        rd       = access && !pwrite;
	wire [11:0] a        = paddr[11:0];
	wire        hit_hi   = (paddr[31:12] == 20'h0);
	wire        sel_ctrl = hit_hi && a == board_ctrl_pkg::ctrl_addr;
	wire        sel_cs   = hit_hi && a == board_ctrl_pkg::ctrl_status_addr;
	wire        sel_wd   = hit_hi && a == board_ctrl_pkg::wd_temp_addr;
	wire        sel_kick = hit_hi && a == board_ctrl_pkg::kick_addr;
	wire        sel_ist  = hit_hi && a == board_ctrl_pkg::irq_status_addr;
	wire        sel_imsk = hit_hi && a == board_ctrl_pkg::irq_mask_addr;
	wire        mapped   = sel_ctrl | sel_cs | sel_wd | sel_kick | sel_ist | sel_imsk;

	// Sensor alarms are active low
	wire temp_pending = !pins_sync_reg.sensor1 || !pins_sync_reg.sensor2;
	wire kick_write   = wr && sel_kick && pwdata[board_ctrl_pkg::kick_bit];
	wire wd_running   = (wd_state_reg == wd_run);
	wire tick         = (prescale_reg == board_ctrl_pkg::prescale_max);
	// A kick in the expiry cycle wins, so a timely trigger never reports a timeout
	wire wd_timeout   = wd_running && tick && !kick_write && (tick_reg == 32'(wd_ticks - 1));
	wire temp_rise    = temp_pending && !temp_prev_reg;
	wire [1:0] events = {temp_rise, wd_timeout};

	// Read data: the reserved upper nibble of the first four registers reads as ones, other reserved bits as zero
	wire [7:0] rd_ctrl = ctrl_reg | {board_ctrl_pkg::reserved_nibble, 4'h0};
	wire [7:0] rd_cs   = {board_ctrl_pkg::reserved_nibble, pins_sync_reg.sensor2, pins_sync_reg.sensor1,
		pins_sync_reg.cable, boot_override_reg};
	wire [7:0] rd_wd   = {board_ctrl_pkg::reserved_nibble, temp_pending, temp_irq_en_reg, wd_running,
		wd_irq_en_reg};
	wire [7:0] rd_kick = {board_ctrl_pkg::reserved_nibble, kick_reg, 3'h0};
	wire [7:0] rd_byte = sel_ctrl ? rd_ctrl :
		sel_cs   ? rd_cs :
		sel_wd   ? rd_wd :
		sel_kick ? rd_kick :
		sel_ist  ? {6'h0, ev_status_reg} :
		sel_imsk ? {6'h0, ev_mask_reg} : board_ctrl_pkg::reserved_read;

	assign pready  = 1'b1;
	assign pslverr = access && !mapped;
	assign prdata  = prdata_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_meta_reg <= board_ctrl_pkg::pins_idle;
			pins_sync_reg <= board_ctrl_pkg::pins_idle;
			boot_meta_reg <= 1'b0;
			boot_sync_reg <= 1'b0;
		end else begin
			pins_meta_reg <= pins;
			pins_sync_reg <= pins_meta_reg;
			boot_meta_reg <= boot_select_switch;
			boot_sync_reg <= boot_meta_reg;
		end
	end

	// Register writes; only defined bits are stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg          <= board_ctrl_pkg::ctrl_reset;
			boot_override_reg <= 1'b0;
			wd_irq_en_reg     <= 1'b0;
			temp_irq_en_reg   <= 1'b0;
			kick_reg          <= 1'b0;
			ev_mask_reg       <= 2'h0;
		end else begin
			if (wr && sel_ctrl) begin
				ctrl_reg <= pwdata[7:0] & 8'h0c;
			end
			if (wr && sel_cs) begin
				boot_override_reg <= pwdata[board_ctrl_pkg::boot_override_bit];
			end
			if (wr && sel_wd) begin
				wd_irq_en_reg   <= pwdata[board_ctrl_pkg::wd_irq_en_bit];
				temp_irq_en_reg <= pwdata[board_ctrl_pkg::temp_irq_en_bit];
			end
			if (wr && sel_kick) begin
				kick_reg <= pwdata[board_ctrl_pkg::kick_bit];
			end
			if (wr && sel_imsk) begin
				ev_mask_reg <= pwdata[1:0];
			end
		end
	end

	// Reset-cause flags: new causes capture, control bit 3 clears; a cause arriving wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cause_reg <= board_ctrl_pkg::reset_cause_w;
		end else if (wr && sel_ctrl && pwdata[board_ctrl_pkg::reset_cause_clear_bit]) begin
			cause_reg <= reset_cause_in;
		end else begin
			cause_reg <= cause_reg | reset_cause_in;
		end
	end

	// Sticky event status, cleared by reading; a new event wins over the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_status_reg <= 2'h0;
			temp_prev_reg <= 1'b0;
			prdata_reg    <= 32'h0;
		end else begin
			temp_prev_reg <= temp_pending;
			ev_status_reg <= ((rd && sel_ist) ? 2'h0 : ev_status_reg) | events;
			if (rd) begin
				prdata_reg <= {24'h0, rd_byte};
			end
		end
	end

	// Watchdog sequencing
	always_comb begin
		wd_state_next = wd_state_reg;
		case (wd_state_reg)
			wd_idle: begin
				if (kick_write && pins_sync_reg.wd_switch) begin
					wd_state_next = wd_run;
				end
			end
			wd_run: begin
				if (!pins_sync_reg.wd_switch) begin
					wd_state_next = wd_idle;
				end else if (wd_timeout) begin
					wd_state_next = wd_expired;
				end
			end
			wd_expired: begin
				if (kick_write && pins_sync_reg.wd_switch) begin
					wd_state_next = wd_run;
				end
			end
			default: wd_state_next = wd_idle;
		endcase
	end

	// Prescaler gives 1 ms ticks; a kick restarts both counters
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_state_reg <= wd_idle;
			prescale_reg <= 16'h0;
			tick_reg     <= 32'h0;
		end else begin
			wd_state_reg <= wd_state_next;
			if (kick_write || !wd_running) begin
				prescale_reg <= 16'h0;
				tick_reg     <= 32'h0;
			end else if (tick) begin
				prescale_reg <= 16'h0;
				tick_reg     <= tick_reg + 32'h1;
			end else begin
				prescale_reg <= prescale_reg + 16'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watchdog_irq <= 1'b0;
			temp_irq     <= 1'b0;
			irq          <= 1'b0;
		end else begin
			watchdog_irq <= (wd_state_next == wd_expired) && wd_irq_en_reg;
			temp_irq     <= temp_pending && temp_irq_en_reg;
			irq          <= |(ev_status_reg & ev_mask_reg);
		end
	end

	assign floppy_eject      = ctrl_reg[board_ctrl_pkg::floppy_eject_bit];
	assign boot_flash_select = boot_override_reg | boot_sync_reg;
	assign reset_cause       = cause_reg;
	assign watchdog_expired  = (wd_state_reg == wd_expired);
endmodule

// ==== board_ctrl_sva.sv ====
// Port assertions for the board control bank
`timescale 1ns/1ps
module board_ctrl_sva (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// Pins and outputs
	input wire board_ctrl_pkg::pins_s pins,
	input wire logic [2:0] reset_cause_in,
	input wire logic floppy_eject,
	input wire logic boot_flash_select,
	input wire logic [2:0] reset_cause,
	input wire logic watchdog_expired,
	input wire logic watchdog_irq,
	input wire logic temp_irq
);
	wire logic acc = psel && penable;
	wire logic wr = acc && pwrite;
	wire logic [11:0] a = paddr[11:0];
	wire logic mapped = paddr[31:12] == 20'h0 && paddr[1:0] == 2'h0
		&& a >= board_ctrl_pkg::ctrl_addr && a <= board_ctrl_pkg::irq_mask_addr;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence ctrl_wr;
		wr && a == board_ctrl_pkg::ctrl_addr;
	endsequence
	// Switch held on first, since the switch input passes a synchroniser
	sequence kick_on;
		pins.wd_switch [*4] ##0 (wr && a == board_ctrl_pkg::kick_addr && pwdata[3]);
	endsequence
	AST_EJECT: assert property (ctrl_wr |=> floppy_eject == $past(pwdata[2]))
		else $error("eject wrong");
	AST_CAUSE_CLR: assert property (ctrl_wr ##0 (pwdata[3] && reset_cause_in == 3'h0) |=> reset_cause == 3'h0)
		else $error("cause not cleared");
	AST_OVERRIDE: assert property (wr && a == board_ctrl_pkg::ctrl_status_addr && pwdata[0] |=> boot_flash_select)
		else $error("override ignored");
	AST_RSVD: assert property (acc && !pwrite && a == board_ctrl_pkg::ctrl_addr |=>
		prdata[31:8] == 24'h0 && prdata[7:4] == 4'hf && prdata[1:0] == 2'h0)
		else $error("reserved bits set");
	AST_UNMAPPED: assert property (acc && !mapped |-> pslverr)
		else $error("no slave error");
	AST_TEMP_IRQ: assert property ((pins.sensor1 && pins.sensor2) [*6] |-> !temp_irq)
		else $error("temp irq without alarm");
	AST_WD_IRQ: assert property (!watchdog_expired [*2] |-> !watchdog_irq)
		else $error("wd irq without expiry");
	AST_KICK: assert property (kick_on |-> ##[1:3] !watchdog_expired)
		else $error("kick ignored");
endmodule

// ==== sensor_model.sv ====
// Behavioural temperature sensor alarm pin, active low
`timescale 1ns/1ps
module sensor_model #(
	parameter int upper_temp_limit = 80,
	parameter int lower_temp_limit = 70
) (
	input wire logic pclk,
	input wire logic int_mode,
	input wire logic [7:0] temp,
	input wire logic i2c_read,
	output logic alarm_n = 1'h1
);
	logic above = 1'h0;
	always @(posedge pclk) begin
		if (temp > upper_temp_limit && !above) begin
			above <= 1'h1;
			alarm_n <= 1'h0;
		end else if (temp < lower_temp_limit && above) begin
			above <= 1'h0;
			alarm_n <= !int_mode;
		end else if (int_mode && i2c_read) begin
			alarm_n <= 1'h1;
		end
	end
endmodule

// ==== testbench.sv ====
// Self-checking bench for the board control bank
`timescale 1ns/1ps
module testbench;
	localparam logic [11:0] a_ctl = board_ctrl_pkg::ctrl_addr;
	localparam logic [11:0] a_cs = board_ctrl_pkg::ctrl_status_addr;
	localparam logic [11:0] a_wd = board_ctrl_pkg::wd_temp_addr;
	localparam logic [11:0] a_ist = board_ctrl_pkg::irq_status_addr;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
	logic pready, pslverr, floppy_eject, boot_flash_select, watchdog_expired, watchdog_irq, temp_irq, irq;
	logic [2:0] reset_cause, reset_cause_in = 3'h0;
	logic cable = 1'h0, wd_switch = 1'h0, imode = 1'h0, rd_i2c = 1'h0, rd_pend = 1'h0, s1, s2;
	logic [7:0] t1 = 8'h19, t2 = 8'h19;
	logic [15:0] q[$];
	int errors = 0, compares = 0;
	board_ctrl_pkg::pins_s pins;
	assign pins = '{sensor1: s1, sensor2: s2, cable: cable, wd_switch: wd_switch};
	initial begin
		forever #10 pclk = ~pclk;
	end
	board_ctrl_regs #(.wd_ticks(1)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'h1), .prdata, .pready, .pslverr, .pins, .boot_select_switch(1'h0), .reset_cause_in,
		.floppy_eject, .boot_flash_select, .reset_cause, .watchdog_expired, .watchdog_irq, .temp_irq, .irq);
	sensor_model sens1 (.pclk, .int_mode(imode), .temp(t1), .i2c_read(rd_i2c), .alarm_n(s1));
	sensor_model sens2 (.pclk, .int_mode(imode), .temp(t2), .i2c_read(rd_i2c), .alarm_n(s2));
	task tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task print_verdict;
		if (errors == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Read data is registered, so the expectation is queued and judged one edge later
	task apb(input int w, input logic [11:0] a, input logic [7:0] d, input logic [7:0] m = 8'hff,
			input logic err = 1'h0);
		psel <= 1'h1;
		pwrite <= (w != 0);
		paddr <= {20'h0, a};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		chk("pslverr", {7'h0, err}, {7'h0, pslverr});
		if (!w) q.push_back({m, d & m});
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	always @(posedge pclk) begin
		if (rd_pend) begin
			chk("prdata", q[0][7:0], prdata[7:0] & q[0][15:8]);
			void'(q.pop_front());
		end
		rd_pend <= psel && penable && pready && !pwrite;
	end
	initial begin
		void'($urandom(83));
		tick(12);
		presetn <= 1'h1;
		tick(3);
		apb(0, a_ctl, 8'hf0);
		apb(0, a_ist, 8'h00);
		apb(0, a_cs, 8'hf0, 8'hf1);
		apb(0, a_wd, 8'hf0, 8'hf7);
		apb(1, a_ctl, 8'hf7);
		apb(0, a_ctl, 8'hf4);
		chk("eject", 8'h1, {7'h0, floppy_eject});
		reset_cause_in <= 3'h5;
		tick(1);
		reset_cause_in <= 3'h0;
		tick(2);
		chk("cause", 8'h5, {5'h0, reset_cause});
		apb(1, a_ctl, 8'h08);
		chk("cause", 8'h0, {5'h0, reset_cause});
		apb(1, a_ctl, 8'h00);
		chk("eject", 8'h0, {7'h0, floppy_eject});
		for (int i = 0; i < 8; i++) begin
			t1 <= 8'($urandom_range(99));
			t2 <= 8'($urandom_range(99));
			cable <= 1'($urandom);
			tick(6);
			apb(0, a_cs, {4'h0, s2, s1, cable, 1'h0}, 8'h0e);
			apb(0, a_wd, {4'h0, !(s1 && s2), 3'h0}, 8'h08);
		end
		apb(1, a_cs, 8'h01);
		chk("boot", 8'h1, {7'h0, boot_flash_select});
		apb(1, a_cs, 8'h00);
		t1 <= 8'h19;
		t2 <= 8'h19;
		tick(6);
		apb(1, board_ctrl_pkg::irq_mask_addr, 8'h02);
		apb(1, a_wd, 8'h04);
		apb(0, a_ist, 8'h00, 8'h00);
		t1 <= 8'h5a;
		tick(6);
		chk("temp_irq", 8'h1, {7'h0, temp_irq});
		chk("irq", 8'h1, {7'h0, irq});
		apb(0, a_ist, 8'h02, 8'h02);
		apb(0, a_ist, 8'h00, 8'h02);
		chk("irq", 8'h0, {7'h0, irq});
		imode <= 1'h1;
		t1 <= 8'h19;
		tick(2);
		rd_i2c <= 1'h1;
		tick(1);
		rd_i2c <= 1'h0;
		tick(5);
		apb(0, a_cs, 8'h04, 8'h04);
		wd_switch <= 1'h1;
		tick(5);
		apb(1, board_ctrl_pkg::kick_addr, 8'h08);
		apb(0, a_wd, 8'h02, 8'h02);
		tick(30000);
		apb(1, board_ctrl_pkg::kick_addr, 8'h08);
		tick(30000);
		apb(0, a_wd, 8'h02, 8'h02);
		apb(1, a_wd, 8'h01);
		tick(20300);
		chk("wd_expired", 8'h1, {7'h0, watchdog_expired});
		chk("wd_irq", 8'h1, {7'h0, watchdog_irq});
		apb(0, a_wd, 8'h01, 8'h03);
		apb(0, 12'h028, 8'h00, 8'hff, 1'h1);
		print_verdict();
	end
	initial begin
		tick(90000);
		errors++;
		print_verdict();
	end
endmodule
bind board_ctrl_regs board_ctrl_sva sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pslverr, .pins, .reset_cause_in, .floppy_eject, .boot_flash_select, .reset_cause, .watchdog_expired,
	.watchdog_irq, .temp_irq);
